// >>> shared/proto_sel_pkg.sv
// Purpose: Constants for the protocol select configuration register bank.
// Assumes: Byte-wide register port with 5-bit addresses.
// Notes:   Offsets, field positions, reset values and encodings live here; some assertions and the host model repeat them as literals.
package proto_sel_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [4:0] OFF_PROTOCOL_SELECT  = 5'h01;
    localparam logic [4:0] OFF_TYPE_B_TX_FRAME  = 5'h02;
    localparam logic [4:0] OFF_TYPE_A_RATE_PAR  = 5'h03;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_PROTOCOL_SELECT  = 8'h02;
    localparam logic [7:0] RST_TYPE_B_TX_FRAME  = 8'h00;
    localparam logic [7:0] RST_TYPE_A_RATE_PAR  = 8'h00;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int POS_RX_CRC_ABSENT = 7;
    localparam int POS_DIRECT_VAR    = 6;
    localparam int POS_READER_MODE   = 5;
    localparam int POS_GUARD_LSB     = 5;
    localparam int POS_EOF_LOW_LONG  = 4;
    localparam int POS_SOF_HIGH_LONG = 3;
    localparam int POS_SOF_LOW_LONG  = 2;
    localparam int POS_GUARD_EVERY   = 1;
    localparam int POS_SEP_TX_RATE   = 7;
    localparam int POS_TX_RATE_LSB   = 5;
    localparam int POS_TX_PARITY     = 4;
    localparam int POS_RX_PARITY     = 3;

    // Writable masks: unused bits read as zero.
    localparam logic [7:0] MASK_TYPE_B_TX_FRAME = 8'hfe;
    localparam logic [7:0] MASK_TYPE_A_RATE_PAR = 8'hf8;

    // ------------------------------------------------------------
    // Protocol codes and decoded families
    // ------------------------------------------------------------
    localparam logic [4:0] CODE_A_106  = 5'h08;
    localparam logic [4:0] CODE_A_848  = 5'h0b;
    localparam logic [4:0] CODE_B_106  = 5'h0c;
    localparam logic [4:0] CODE_B_848  = 5'h0f;
    localparam logic [4:0] CODE_P_212  = 5'h1a;
    localparam logic [4:0] CODE_P_424  = 5'h1b;

    typedef enum logic [1:0] {
        FAM_NONE = 2'b00,
        FAM_A    = 2'b01,
        FAM_B    = 2'b10,
        FAM_PROP = 2'b11
    } family_e;

    // Rate encoding: 0=106, 1=212, 2=424, 3=848 kbps.
    localparam logic [1:0] RATE_106 = 2'h0;
    localparam logic [1:0] RATE_212 = 2'h1;
    localparam logic [1:0] RATE_424 = 2'h2;
    localparam logic [1:0] RATE_848 = 2'h3;

    // ------------------------------------------------------------
    // Framing lengths in elementary time units
    // ------------------------------------------------------------
    localparam logic [3:0] ETU_LOW_SHORT  = 4'ha;
    localparam logic [3:0] ETU_LOW_LONG   = 4'hb;
    localparam logic [3:0] ETU_HIGH_SHORT = 4'h2;
    localparam logic [3:0] ETU_HIGH_LONG  = 4'h3;

endpackage : proto_sel_pkg

// >>> logic/proto_sel_regs.sv
// Purpose: Protocol select and transmit option registers of the reader front end.
// Assumes: Host register port is synchronous to ref_clk_i, one write per strobe.
// Notes:   Decoded settings are registered outputs for the framer and decoders.
//
// Functional notes
// R1: Receive CRC bit set means no CRC expected; cleared means CRC checked.
// R2: Direct variant bit selects direct mode 0 when clear, 1 when set.
// R3: Host writes zero to the reader-mode bit; one is reserved.
// R4: Codes 01000 to 01011 select type A receive at 106/212/424/848.
// R5: Codes 01100-01111 type B rates; 11010/11011 proprietary 212/424.
// R6: Host sets a differing transmit rate through the option registers.
// R7: Three-bit guard field gives 0 to 7 units between type B characters.
// R8: Type B end-of-frame low lasts 11 units when set, else 10.
// R9: Type B start-of-frame high lasts 3 units when set, else 2.
// R10: Type B start-of-frame low lasts 11 units when set, else 10.
// R11: Guard placement set: guard after every byte; clear: none after last.
// R12: Separate transmit rate used only while its enable bit is set.
// R13: Transmit rate field 00/01/10/11 means 106/212/424/848 kbps.
// R14: Transmit parity option: odd parity on all bytes, even on the last.
// R15: Receive parity option: check odd on all bytes, even on the last.
// R16: Type A rate/parity register clears on reset, enable low, protocol write.
// R17: Protocol select register resets to 0x02 on reset or enable low.
// R18: Host sets the direct variant before enabling direct operation.
// R19: Host writes only the ten listed protocol codes.
`timescale 1ns/1ps

module proto_sel_regs
    import proto_sel_pkg::*;
(
    // Clock and reset.
    input  wire logic       ref_clk_i,
    input  wire logic       rst_i,
    input  wire logic       enable_i,
    // Host register port.
    input  wire logic [4:0] reg_addr_i,
    input  wire logic       reg_wr_i,
    input  wire logic [7:0] reg_wdata_i,
    output logic      [7:0] reg_rdata_o,
    output logic            reg_hit_o,
    // Decoded receive settings.
    output logic            rx_crc_check_o,
    output logic            direct_variant_o,
    output logic      [1:0] family_o,
    output logic      [1:0] rx_rate_o,
    // Decoded type B transmit framing.
    output logic      [2:0] guard_units_o,
    output logic            guard_after_last_o,
    output logic      [3:0] eof_low_etu_o,
    output logic      [3:0] sof_high_etu_o,
    output logic      [3:0] sof_low_etu_o,
    // Decoded transmit rate and type A transmit and receive parity settings.
    output logic      [1:0] tx_rate_o,
    output logic            tx_last_byte_even_parity_o,
    output logic            rx_last_byte_even_parity_o
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [7:0] protocol_select_q;
    logic [7:0] type_b_tx_framing_options_q;
    logic [7:0] type_a_rate_parity_options_q;

    // Address decode shared by writes and reads.
    function automatic logic addr_is(input logic [4:0] a, input logic [4:0] off);
        return a == off;
    endfunction : addr_is

    wire logic wr_proto = reg_wr_i & addr_is(reg_addr_i, OFF_PROTOCOL_SELECT);
    wire logic wr_b     = reg_wr_i & addr_is(reg_addr_i, OFF_TYPE_B_TX_FRAME);
    wire logic wr_a     = reg_wr_i & addr_is(reg_addr_i, OFF_TYPE_A_RATE_PAR);

    // Enable low acts as a synchronous clear; the async reset stays constant-only.
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            protocol_select_q <= RST_PROTOCOL_SELECT;                 // R17
        end else if (!enable_i) begin
            protocol_select_q <= RST_PROTOCOL_SELECT;                 // R17
        end else if (wr_proto) begin
            protocol_select_q <= reg_wdata_i;                         // R3
        end
    end

    // Type B framing options hold their value across protocol writes.
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            type_b_tx_framing_options_q <= RST_TYPE_B_TX_FRAME;
        end else if (!enable_i) begin
            type_b_tx_framing_options_q <= RST_TYPE_B_TX_FRAME;
        end else if (wr_b) begin
            type_b_tx_framing_options_q <= reg_wdata_i & MASK_TYPE_B_TX_FRAME;
        end
    end

    // A protocol write clears the type A options, even if both hit together.
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            type_a_rate_parity_options_q <= RST_TYPE_A_RATE_PAR;      // R16
        end else if (!enable_i || wr_proto) begin
            type_a_rate_parity_options_q <= RST_TYPE_A_RATE_PAR;      // R16
        end else if (wr_a) begin
            type_a_rate_parity_options_q <= reg_wdata_i & MASK_TYPE_A_RATE_PAR;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    wire logic hit_p = addr_is(reg_addr_i, OFF_PROTOCOL_SELECT);
    wire logic hit_b = addr_is(reg_addr_i, OFF_TYPE_B_TX_FRAME);
    wire logic hit_a = addr_is(reg_addr_i, OFF_TYPE_A_RATE_PAR);
    assign reg_hit_o   = hit_p | hit_b | hit_a;
    // Unmapped addresses read as zero.
    assign reg_rdata_o = hit_p ? protocol_select_q :
                         hit_b ? type_b_tx_framing_options_q :
                         hit_a ? type_a_rate_parity_options_q : 8'h00;

    // ------------------------------------------------------------
    // Protocol decode
    // ------------------------------------------------------------
    wire logic [4:0] code = protocol_select_q[4:0];
    wire logic is_a = (code >= CODE_A_106) && (code <= CODE_A_848);   // R4
    wire logic is_b = (code >= CODE_B_106) && (code <= CODE_B_848);   // R5
    wire logic is_p = (code == CODE_P_212) || (code == CODE_P_424);   // R5
    // Unlisted codes decode to no family; their behaviour is left undefined.
    wire family_e fam_d = is_a ? FAM_A : is_b ? FAM_B : is_p ? FAM_PROP : FAM_NONE;
    // Proprietary codes map 1a->212, 1b->424; A/B take the low two bits.
    wire logic [1:0] rxr_d = is_p ? (code[0] ? RATE_424 : RATE_212) : code[1:0];

    wire logic [7:0] bo = type_b_tx_framing_options_q;
    wire logic [7:0] ao = type_a_rate_parity_options_q;
    wire logic high_rate = (fam_d == FAM_A) || (fam_d == FAM_B);
    // Separate rate is only honoured for type A or B.
    wire logic use_sep = ao[POS_SEP_TX_RATE] & high_rate;             // R12
    wire logic [1:0] txr_d = use_sep ? ao[POS_TX_RATE_LSB +: 2] : rxr_d; // R13

    // Settings are registered so downstream sees glitch-free values.
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_crc_check_o             <= 1'b0;
            direct_variant_o           <= 1'b0;
            family_o                   <= FAM_NONE;
            rx_rate_o                  <= RATE_106;
            guard_units_o              <= 3'h0;
            guard_after_last_o         <= 1'b0;
            eof_low_etu_o              <= ETU_LOW_SHORT;
            sof_high_etu_o             <= ETU_HIGH_SHORT;
            sof_low_etu_o              <= ETU_LOW_SHORT;
            tx_rate_o                  <= RATE_106;
            tx_last_byte_even_parity_o <= 1'b0;
            rx_last_byte_even_parity_o <= 1'b0;
        end else begin
            rx_crc_check_o     <= ~protocol_select_q[POS_RX_CRC_ABSENT];   // R1
            direct_variant_o   <= protocol_select_q[POS_DIRECT_VAR];       // R2
            family_o           <= fam_d;                                   // R4
            rx_rate_o          <= rxr_d;                                   // R5
            guard_units_o      <= bo[POS_GUARD_LSB +: 3];                  // R7
            guard_after_last_o <= bo[POS_GUARD_EVERY];                     // R11
            eof_low_etu_o  <= bo[POS_EOF_LOW_LONG]  ? ETU_LOW_LONG  : ETU_LOW_SHORT;  // R8
            sof_high_etu_o <= bo[POS_SOF_HIGH_LONG] ? ETU_HIGH_LONG : ETU_HIGH_SHORT; // R9
            sof_low_etu_o  <= bo[POS_SOF_LOW_LONG]  ? ETU_LOW_LONG  : ETU_LOW_SHORT;  // R10
            tx_rate_o          <= txr_d;                                   // R12
            tx_last_byte_even_parity_o <= ao[POS_TX_PARITY] & (fam_d == FAM_A); // R14
            rx_last_byte_even_parity_o <= ao[POS_RX_PARITY] & (fam_d == FAM_A); // R15
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_proto_wr;
        enable_i && reg_wr_i && reg_addr_i == OFF_PROTOCOL_SELECT;
    endsequence

    a_opts_clear_wr: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R16
        s_proto_wr |=> type_a_rate_parity_options_q == 8'h00)
        else $error("type A options not cleared by protocol write");
    a_enable_low_rst: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R17
        !enable_i |=> protocol_select_q == 8'h02)
        else $error("protocol select not reset by enable low");
    a_crc_follows: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R1
        s_proto_wr ##1 1'b1 |=> rx_crc_check_o == !$past(reg_wdata_i[7], 2))
        else $error("crc expectation wrong after write");
    a_direct_var: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R2
        ##1 direct_variant_o == $past(protocol_select_q[6]))
        else $error("direct variant mismatch");
    a_type_a_rate: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R4
        protocol_select_q[4:0] == 5'h0a |=> family_o == FAM_A && rx_rate_o == 2'h2)
        else $error("type A 424 decode wrong");
    a_prop_rate: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R5
        protocol_select_q[4:0] == 5'h1b |=> family_o == FAM_PROP && rx_rate_o == 2'h2)
        else $error("proprietary 424 decode wrong");
    a_eof_len: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R8
        type_b_tx_framing_options_q[4] |=> eof_low_etu_o == 4'hb)
        else $error("end-of-frame low length wrong");
    a_sof_high: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R9
        !type_b_tx_framing_options_q[3] |=> sof_high_etu_o == 4'h2)
        else $error("start-of-frame high length wrong");
    a_tx_rate_sel: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R12
        !type_a_rate_parity_options_q[7] |=> tx_rate_o == rx_rate_o)
        else $error("transmit rate not following receive rate");
    a_guard_units: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R7
        ##1 guard_units_o == $past(type_b_tx_framing_options_q[7:5]))
        else $error("guard units mismatch");
    a_sof_low_len: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R10
        bo[POS_SOF_LOW_LONG] |=> sof_low_etu_o == ETU_LOW_LONG)
        else $error("start-of-frame low length wrong");
    a_guard_every: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R11
        bo[POS_GUARD_EVERY] |=> guard_after_last_o)
        else $error("guard placement flag not passed on");
    a_tx_sep_rate: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R13
        ao[POS_SEP_TX_RATE] && (is_a || is_b) |=> tx_rate_o == $past(ao[6:5]))
        else $error("separate transmit rate not applied");
    a_tx_parity: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R14
        ao[POS_TX_PARITY] && is_a |=> tx_last_byte_even_parity_o)
        else $error("transmit parity option not applied");
    a_rx_parity: assert property (@(posedge ref_clk_i) disable iff (rst_i) // R15
        ao[POS_RX_PARITY] && is_a |=> rx_last_byte_even_parity_o)
        else $error("receive parity option not applied");

endmodule : proto_sel_regs

// >>> sim/host_model.sv
// Purpose: Host model that drives the register port of the protocol select bank.
// Assumes: Writes are one-cycle strobes launched just after a rising edge.
// Notes:   Write data is inverted once the strobe drops, so stale data never looks valid.
`timescale 1ns/1ps

module host_model (
    // Clock.
    input  wire logic       ref_clk_i,
    // Register port towards the device.
    output logic      [4:0] reg_addr_o,
    output logic            reg_wr_o,
    output logic      [7:0] reg_wdata_o
);
    // ------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------
    // Idle values from time zero keep the strobe out of the unknown state.
    initial begin
        reg_addr_o  = 5'h00;
        reg_wr_o    = 1'b0;
        reg_wdata_o = 8'h00;
    end

    // One write; the address stays put afterwards so the bench can read back.
    task automatic write(input logic [4:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        reg_addr_o  <= a;
        reg_wr_o    <= 1'b1;
        reg_wdata_o <= (a == 5'h01) ? (d & 8'hdf) : d;
        @(posedge ref_clk_i);
        reg_wr_o    <= 1'b0;
        reg_wdata_o <= ~reg_wdata_o;
    endtask : write

    // A read is only an address change, since read data is combinational.
    task automatic read(input logic [4:0] a);
        @(posedge ref_clk_i);
        reg_addr_o <= a;
    endtask : read
endmodule : host_model

// >>> sim/proto_sel_regs_bench.sv
// Purpose: Self-checking bench for the protocol select register bank.
// Assumes: Decoded outputs follow a register write by one clock edge.
// Notes:   Expected outputs come from shadow registers kept by the bench.
`timescale 1ns/1ps

module proto_sel_regs_bench;
    import proto_sel_pkg::*;
    logic        ref_clk_i = 1'b0;
    logic        rst_i     = 1'b1;
    logic        enable_i  = 1'b1;
    logic [4:0]  reg_addr;
    logic        reg_wr, reg_hit, crc_chk, dir_var, gal, txp, rxp;
    logic [7:0]  reg_wdata, reg_rdata;
    logic [1:0]  family, rx_rate, tx_rate;
    logic [2:0]  guard;
    logic [3:0]  eof_l, sof_h, sof_l;
    logic [7:0]  p_m = 8'h02, b_m = 8'h00, a_m = 8'h00;
    logic [34:0] q[$];
    logic [34:0] got;
    logic [31:0] seed = 32'h1499;
    int          error_cnt = 0, checked = 0;
    event        chk_ev;

    // ------------------------------------------------------------
    // Device, host and observation
    // ------------------------------------------------------------
    proto_sel_regs dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .enable_i(enable_i),
        .reg_addr_i(reg_addr), .reg_wr_i(reg_wr), .reg_wdata_i(reg_wdata),
        .reg_rdata_o(reg_rdata), .reg_hit_o(reg_hit), .rx_crc_check_o(crc_chk),
        .direct_variant_o(dir_var), .family_o(family), .rx_rate_o(rx_rate),
        .guard_units_o(guard), .guard_after_last_o(gal), .eof_low_etu_o(eof_l),
        .sof_high_etu_o(sof_h), .sof_low_etu_o(sof_l), .tx_rate_o(tx_rate),
        .tx_last_byte_even_parity_o(txp), .rx_last_byte_even_parity_o(rxp));
    host_model host_u (.ref_clk_i(ref_clk_i), .reg_addr_o(reg_addr), .reg_wr_o(reg_wr),
        .reg_wdata_o(reg_wdata));
    assign got = {reg_rdata, reg_hit, family, rx_rate, crc_chk, dir_var, guard, gal,
                  eof_l, sof_h, sof_l, tx_rate, txp, rxp};

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // Expected output vector for the shadow state and the current address.
    function automatic logic [34:0] expv(input logic [4:0] a);
        logic [4:0] c;
        logic [1:0] f, r;
        logic [7:0] rd;
        c  = p_m[4:0];
        f  = (c[4:2] == 3'b010) ? 2'd1 : (c[4:2] == 3'b011) ? 2'd2 :
             (c[4:1] == 4'hd) ? 2'd3 : 2'd0;
        r  = (f == 2'd3) ? c[1:0] - 2'd1 : c[1:0];
        rd = (a == OFF_PROTOCOL_SELECT) ? p_m : (a == OFF_TYPE_B_TX_FRAME) ?
             (b_m & MASK_TYPE_B_TX_FRAME) : (a == OFF_TYPE_A_RATE_PAR) ?
             (a_m & MASK_TYPE_A_RATE_PAR) : 8'h00;
        return {rd, (a >= 5'h01 && a <= 5'h03), f, r, ~p_m[7], p_m[6],
                b_m[7:5], b_m[1], b_m[4] ? 4'hb : 4'ha, b_m[3] ? 4'h3 : 4'h2,
                b_m[2] ? 4'hb : 4'ha,
                (a_m[7] && f[1] != f[0]) ? a_m[6:5] : r,
                a_m[4] && f == 2'd1, a_m[3] && f == 2'd1};
    endfunction : expv

    // Checks sit on the falling edge, where every output has settled.
    task automatic chk();
        @(negedge ref_clk_i);
        q.push_back(expv(reg_addr));
        -> chk_ev;
    endtask : chk

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        host_u.write(a, d);
        if (enable_i === 1'b1 && a == OFF_PROTOCOL_SELECT) begin
            p_m = d & 8'hdf;
            a_m = 8'h00;
        end
        if (enable_i === 1'b1 && a == OFF_TYPE_B_TX_FRAME) b_m = d;
        if (enable_i === 1'b1 && a == OFF_TYPE_A_RATE_PAR) a_m = d;
        @(posedge ref_clk_i);
        chk();
    endtask : wr

    task automatic rd(input logic [4:0] a);
        host_u.read(a);
        chk();
    endtask : rd

    task automatic conclude();
        $display("Comparisons: %0d, mismatches: %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : conclude

    // ------------------------------------------------------------
    // Clock, monitor, watchdog and stimulus
    // ------------------------------------------------------------
    initial begin
        forever #20 ref_clk_i = ~ref_clk_i;
    end

    // Takes the oldest note whenever a result is announced.
    initial begin
        forever begin
            @(chk_ev);
            checked++;
            if (got !== q[0]) begin
                error_cnt++;
                $display("ERROR %0t: outputs %h expected %h", $time, got, q[0]);
            end
            void'(q.pop_front());
        end
    end

    // A hung sequence counts as a mismatch and still ends in the report.
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        error_cnt++;
        conclude();
    end

    initial begin
        logic [4:0]  codes [10] = '{5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d,
                                   5'h0e, 5'h0f, 5'h1a, 5'h1b};
        logic [31:0] r;
        repeat (3) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        rd(5'h00);
        rd(OFF_PROTOCOL_SELECT);
        rd(OFF_TYPE_B_TX_FRAME);
        rd(OFF_TYPE_A_RATE_PAR);
        foreach (codes[i]) begin
            r = rnd();
            wr(OFF_PROTOCOL_SELECT, {r[7:6], 1'b0, codes[i]});
            wr(OFF_TYPE_A_RATE_PAR, r[15:8]);
            wr(OFF_TYPE_B_TX_FRAME, r[23:16]);
            wr(5'h04, r[31:24]);
            rd(OFF_TYPE_A_RATE_PAR);
        end
        wr(OFF_PROTOCOL_SELECT, 8'h48);
        rd(OFF_TYPE_A_RATE_PAR);
        @(posedge ref_clk_i);
        enable_i <= 1'b0;
        p_m = 8'h02;
        b_m = 8'h00;
        a_m = 8'h00;
        wr(OFF_TYPE_B_TX_FRAME, 8'hff);
        @(posedge ref_clk_i);
        enable_i <= 1'b1;
        rd(OFF_PROTOCOL_SELECT);
        @(posedge ref_clk_i);
        conclude();
    end
endmodule : proto_sel_regs_bench
